/* File: logic/plut_map.vh */
`ifndef PLUT_MAP_VH
`define PLUT_MAP_VH

// ****************************************************************
// Register offsets, printed as byte offsets on the 9-bit port.
// ****************************************************************
`define PLUT_ADDR_W          9
`define PLUT_OFS_MODE        9'h1e0
`define PLUT_OFS_INDEX       9'h1e2
`define PLUT_OFS_DATA        9'h1e4
`define PLUT_OFS_DISP_CFG    9'h1e6

// ****************************************************************
// Field positions.
// ****************************************************************
`define PLUT_MODE_MSB        1
`define PLUT_DATA_LSB        4
`define PLUT_CFG_BPP_LSB     0
`define PLUT_CFG_BPP_MSB     1
`define PLUT_CFG_COLOR_BIT   2
`define PLUT_CFG_DITHER_BIT  3
`define PLUT_CFG_PASSIVE_BIT 4
`define PLUT_CFG_IDD_BIT     5

// ****************************************************************
// Encodings.
// ****************************************************************
`define PLUT_BPP_4           2'h0
`define PLUT_BPP_8           2'h1
`define PLUT_BPP_15          2'h2
`define PLUT_BPP_16          2'h3
`define PLUT_LM_NORMAL       2'h0
`define PLUT_LM_LCD_ONLY     2'h1
`define PLUT_LM_CRT_ONLY     2'h2
`define PLUT_LM_CRT_RD_BOTH  2'h3

// ****************************************************************
// Reset values.
// ****************************************************************
`define PLUT_RST_MODE        2'h0
`define PLUT_RST_INDEX       8'h00
`define PLUT_RST_DISP_CFG    6'h00

`endif

/* File: logic/plut_lut_bank.v */
`timescale 1ns/10ps

// ****************************************************************
// One palette table: red, green and blue banks in flip-flops.
// ****************************************************************
module plut_lut_bank #(
  parameter ENTRIES = 256,
  parameter AW      = 8,
  parameter CW      = 4
) (
  input  wire          clk,      // System clock.
  input  wire          wr_en,    // Write one component.
  input  wire [AW-1:0] cpu_addr, // Entry for CPU access.
  input  wire [2:0]    cpu_comp, // One-hot component: red, green, blue.
  input  wire [CW-1:0] wr_data,  // Component value to write.
  output reg  [CW-1:0] cpu_data, // Component value at cpu_addr.
  input  wire [AW-1:0] pix_addr, // Entry for the pixel path.
  output wire [CW-1:0] pix_red,  // Red at pix_addr.
  output wire [CW-1:0] pix_green,// Green at pix_addr.
  output wire [CW-1:0] pix_blue  // Blue at pix_addr.
);

  reg [CW-1:0] red_mem   [0:ENTRIES-1];
  reg [CW-1:0] green_mem [0:ENTRIES-1];
  reg [CW-1:0] blue_mem  [0:ENTRIES-1];

  // Palette contents are data, not control, so they carry no reset.
  always @(posedge clk) begin
    if (wr_en && cpu_comp[0]) begin
      red_mem[cpu_addr] <= wr_data;
    end
    if (wr_en && cpu_comp[1]) begin
      green_mem[cpu_addr] <= wr_data;
    end
    if (wr_en && cpu_comp[2]) begin
      blue_mem[cpu_addr] <= wr_data;
    end
  end

  always @* begin
    case (cpu_comp)
      3'h1:    cpu_data = red_mem[cpu_addr];
      3'h2:    cpu_data = green_mem[cpu_addr];
      3'h4:    cpu_data = blue_mem[cpu_addr];
      default: cpu_data = {CW{1'b0}};
    endcase
  end

  assign pix_red   = red_mem[pix_addr];
  assign pix_green = green_mem[pix_addr];
  assign pix_blue  = blue_mem[pix_addr];

endmodule // plut_lut_bank

/* File: logic/plut_top.v */
// Contract
// - 15 bpp pixel: ignored top bit, then 5-bit red, green, blue.
// - At 15 and 16 bpp the tables are bypassed.
// - Dithering on: full 15/16 bpp colour range on every display.
// - Dithering off: passive panel keeps four MSBs per colour; TFT, CRT full.
// - Mono at 15 bpp: 5-bit green, 32 grays; 16 without dithering.
// - 16 bpp pixel: red 15..11, green 10..5, blue 4..0.
// - Mono at 16 bpp: 6-bit green, 64 grays; 16 without dithering.
// - Two independent 256-entry tables, LCD and CRT, 4-bit RGB each.
// - 4 bpp uses first 16 entries; 8 bpp uses all 256.
// - Colour selects full RGB entry; mono takes green at index.
// - Colour/mono select bit zero means monochrome panel.
// - At 4 and 8 bpp the CRT path always uses RGB from its own table.
// - Two-bit mode field picks tables reached by CPU accesses.
// - Mode 00h: reads LCD table, writes both tables identically.
// - Writing the entry index selects one entry and resets bank to red.
// - Every third data access increments the entry index by one.
// - Data register holds 4-bit value in bits 7..4; access advances bank.
// - Data accesses visit red, green, blue in that order.
// - After third access bank wraps to red as index increments.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "plut_map.vh"

module plut_top #(
  parameter ENTRIES = 256,
  parameter AW      = 8,
  parameter CW      = 4,
  parameter OW      = 6
) (
  input  wire                    clk,         // 40 MHz system clock.
  input  wire                    rst_n,       // Synchronous reset, active low.
  input  wire [`PLUT_ADDR_W-1:0] reg_addr,    // Register byte offset.
  input  wire [7:0]              reg_wdata,   // Register write data.
  input  wire                    reg_we,      // Write strobe.
  input  wire                    reg_re,      // Read strobe.
  output reg  [7:0]              reg_rdata,   // Read data, cycle after strobe.
  input  wire                    pix_valid,   // Pixel word present.
  input  wire [15:0]             pix_data,    // Pixel word from display buffer.
  output reg                     out_valid,   // Output pixel present.
  output reg  [OW-1:0]           lcd_red,     // Panel red, MSB aligned.
  output reg  [OW-1:0]           lcd_green,   // Panel green, MSB aligned.
  output reg  [OW-1:0]           lcd_blue,    // Panel blue, MSB aligned.
  output reg  [OW-1:0]           lcd_gray,    // Panel gray intensity, MSB aligned.
  output reg  [OW-1:0]           crt_red,     // CRT/TV red, MSB aligned.
  output reg  [OW-1:0]           crt_green,   // CRT/TV green, MSB aligned.
  output reg  [OW-1:0]           crt_blue,    // CRT/TV blue, MSB aligned.
  output reg                     lut_bypass   // Output came straight from pixel.
);

  // ****************************************************************
  // Bank pointer states.
  // ****************************************************************
  localparam [2:0] BANK_RED   = 3'b001;
  localparam [2:0] BANK_GREEN = 3'b010;
  localparam [2:0] BANK_BLUE  = 3'b100;

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Keeps only the four most significant bits of an MSB-aligned field.
  function [OW-1:0] keep_msb4;
    input [OW-1:0] v;
    begin
      keep_msb4 = {v[OW-1:OW-4], {(OW-4){1'b0}}};
    end
  endfunction

  // Widens a 4-bit table value to the output width, MSB aligned.
  function [OW-1:0] widen4;
    input [CW-1:0] v;
    begin
      widen4 = {v, {(OW-CW){1'b0}}};
    end
  endfunction

  // Widens a 5-bit pixel field to the output width, MSB aligned.
  function [OW-1:0] widen5;
    input [4:0] v;
    begin
      widen5 = {v, 1'b0};
    end
  endfunction

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  reg  [1:0]    mode_reg;
  reg  [1:0]    mode_next;
  reg  [AW-1:0] index_reg;
  reg  [AW-1:0] index_next;
  reg  [2:0]    bank_reg;
  reg  [2:0]    bank_next;
  reg  [5:0]    cfg_reg;
  reg  [5:0]    cfg_next;
  reg  [7:0]    rdata_next;

  wire          hit_mode;
  wire          hit_index;
  wire          hit_data;
  wire          hit_cfg;
  wire          data_access;
  wire          wr_lcd;
  wire          wr_crt;
  wire          rd_crt;
  wire [CW-1:0] lcd_cpu_data;
  wire [CW-1:0] crt_cpu_data;
  wire [CW-1:0] sel_cpu_data;

  assign hit_mode    = (reg_addr == `PLUT_OFS_MODE);
  assign hit_index   = (reg_addr == `PLUT_OFS_INDEX);
  assign hit_data    = (reg_addr == `PLUT_OFS_DATA);
  assign hit_cfg     = (reg_addr == `PLUT_OFS_DISP_CFG);
  assign data_access = hit_data && (reg_we || reg_re);

  // Mode 00 writes both tables and reads the panel table.
  assign wr_lcd = reg_we && hit_data && (mode_reg != `PLUT_LM_CRT_ONLY);
  assign wr_crt = reg_we && hit_data && (mode_reg != `PLUT_LM_LCD_ONLY);
  assign rd_crt = (mode_reg == `PLUT_LM_CRT_ONLY) ||
                  (mode_reg == `PLUT_LM_CRT_RD_BOTH);
  assign sel_cpu_data = rd_crt ? crt_cpu_data : lcd_cpu_data;

  always @* begin
    mode_next = mode_reg;
    if (reg_we && hit_mode) begin
      mode_next = reg_wdata[`PLUT_MODE_MSB:0];
    end
  end

  always @* begin
    cfg_next = cfg_reg;
    if (reg_we && hit_cfg) begin
      cfg_next = reg_wdata[5:0];
    end
  end

  // The index write and the bank step share one path, so a data access
  // can never leave the pointer between entries.
  always @* begin
    index_next = index_reg;
    bank_next  = bank_reg;
    if (reg_we && hit_index) begin
      index_next = reg_wdata;
      bank_next  = BANK_RED;
    end else if (data_access) begin
      case (bank_reg)
        BANK_RED: begin
          bank_next = BANK_GREEN;
        end
        BANK_GREEN: begin
          bank_next = BANK_BLUE;
        end
        BANK_BLUE: begin
          bank_next  = BANK_RED;
          // Natural 8-bit overflow carries 255 back to 0.
          index_next = index_reg + {{(AW-1){1'b0}}, 1'b1};
        end
        default: begin
          bank_next = BANK_RED;
        end
      endcase
    end
  end

  always @* begin
    rdata_next = 8'h00;
    if (reg_re) begin
      if (hit_mode) begin
        rdata_next = {6'h00, mode_reg};
      end else if (hit_index) begin
        rdata_next = index_reg;
      end else if (hit_data) begin
        rdata_next = {sel_cpu_data, 4'h0};
      end else if (hit_cfg) begin
        rdata_next = {2'h0, cfg_reg};
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      mode_reg  <= `PLUT_RST_MODE;
      index_reg <= `PLUT_RST_INDEX;
      bank_reg  <= BANK_RED;
      cfg_reg   <= `PLUT_RST_DISP_CFG;
      reg_rdata <= 8'h00;
    end else begin
      mode_reg  <= mode_next;
      index_reg <= index_next;
      bank_reg  <= bank_next;
      cfg_reg   <= cfg_next;
      reg_rdata <= rdata_next;
    end
  end

  // ****************************************************************
  // Display configuration fields.
  // ****************************************************************
  wire [1:0] bpp;
  wire       color_panel;
  wire       dither_on;
  wire       passive;

  assign bpp         = cfg_reg[`PLUT_CFG_BPP_MSB:`PLUT_CFG_BPP_LSB];
  assign color_panel = cfg_reg[`PLUT_CFG_COLOR_BIT];
  assign dither_on   = cfg_reg[`PLUT_CFG_DITHER_BIT];
  assign passive     = cfg_reg[`PLUT_CFG_PASSIVE_BIT];

  // ****************************************************************
  // Palette tables.
  // ****************************************************************
  wire [AW-1:0] pix_index;
  wire [CW-1:0] lcd_tr;
  wire [CW-1:0] lcd_tg;
  wire [CW-1:0] lcd_tb;
  wire [CW-1:0] crt_tr;
  wire [CW-1:0] crt_tg;
  wire [CW-1:0] crt_tb;

  // At 4 bpp only the low nibble indexes, so entries 16..255 stay unseen.
  assign pix_index = (bpp == `PLUT_BPP_4) ? {{(AW-4){1'b0}}, pix_data[3:0]} :
                     pix_data[AW-1:0];

  plut_lut_bank #(
    .ENTRIES (ENTRIES),
    .AW      (AW),
    .CW      (CW)
  ) u_lcd_bank (
    .clk       (clk),
    .wr_en     (wr_lcd),
    .cpu_addr  (index_reg),
    .cpu_comp  (bank_reg),
    .wr_data   (reg_wdata[7:`PLUT_DATA_LSB]),
    .cpu_data  (lcd_cpu_data),
    .pix_addr  (pix_index),
    .pix_red   (lcd_tr),
    .pix_green (lcd_tg),
    .pix_blue  (lcd_tb)
  );

  plut_lut_bank #(
    .ENTRIES (ENTRIES),
    .AW      (AW),
    .CW      (CW)
  ) u_crt_bank (
    .clk       (clk),
    .wr_en     (wr_crt),
    .cpu_addr  (index_reg),
    .cpu_comp  (bank_reg),
    .wr_data   (reg_wdata[7:`PLUT_DATA_LSB]),
    .cpu_data  (crt_cpu_data),
    .pix_addr  (pix_index),
    .pix_red   (crt_tr),
    .pix_green (crt_tg),
    .pix_blue  (crt_tb)
  );

  // ****************************************************************
  // Pixel unpacking.
  // ****************************************************************
  reg  [OW-1:0] pr;
  reg  [OW-1:0] pg;
  reg  [OW-1:0] pb;
  reg  [OW-1:0] lr_next;
  reg  [OW-1:0] lg_next;
  reg  [OW-1:0] lb_next;
  reg  [OW-1:0] gray_next;
  reg  [OW-1:0] cr_next;
  reg  [OW-1:0] cg_next;
  reg  [OW-1:0] cb_next;
  wire          direct;
  wire          trim;

  assign direct = (bpp == `PLUT_BPP_15) || (bpp == `PLUT_BPP_16);
  // Without dithering the modulator can only hold four bits on a passive
  // panel; monochrome panels are passive, so gray is trimmed the same way.
  assign trim   = !dither_on && passive;

  always @* begin
    if (bpp == `PLUT_BPP_15) begin
      pr = widen5(pix_data[14:10]);
      pg = widen5(pix_data[9:5]);
      pb = widen5(pix_data[4:0]);
    end else begin
      pr = widen5(pix_data[15:11]);
      pg = pix_data[10:5];
      pb = widen5(pix_data[4:0]);
    end
  end

  always @* begin
    if (direct) begin
      lr_next = trim ? keep_msb4(pr) : pr;
      lg_next = trim ? keep_msb4(pg) : pg;
      lb_next = trim ? keep_msb4(pb) : pb;
      gray_next = dither_on ? pg : keep_msb4(pg);
      cr_next = pr;
      cg_next = pg;
      cb_next = pb;
    end else begin
      lr_next   = widen4(lcd_tr);
      lg_next   = widen4(lcd_tg);
      lb_next   = widen4(lcd_tb);
      gray_next = widen4(lcd_tg);
      cr_next   = widen4(crt_tr);
      cg_next   = widen4(crt_tg);
      cb_next   = widen4(crt_tb);
    end
    if (!color_panel) begin
      lr_next = {OW{1'b0}};
      lg_next = {OW{1'b0}};
      lb_next = {OW{1'b0}};
    end else begin
      gray_next = {OW{1'b0}};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      out_valid  <= 1'b0;
      lcd_red    <= {OW{1'b0}};
      lcd_green  <= {OW{1'b0}};
      lcd_blue   <= {OW{1'b0}};
      lcd_gray   <= {OW{1'b0}};
      crt_red    <= {OW{1'b0}};
      crt_green  <= {OW{1'b0}};
      crt_blue   <= {OW{1'b0}};
      lut_bypass <= 1'b0;
    end else begin
      out_valid <= pix_valid;
      if (pix_valid) begin
        lcd_red    <= lr_next;
        lcd_green  <= lg_next;
        lcd_blue   <= lb_next;
        lcd_gray   <= gray_next;
        crt_red    <= cr_next;
        crt_green  <= cg_next;
        crt_blue   <= cb_next;
        lut_bypass <= direct;
      end
    end
  end

endmodule // plut_top

/* File: verif/plut_monitor.sv */
`timescale 1ns/10ps
`include "plut_map.vh"

// ****************************************************************
// Port checker for the palette and pixel unpack block.
// ****************************************************************
module plut_monitor #(
  parameter OW = 6
) (
  input wire                    clk,        // Clock.
  input wire                    rst_n,      // Reset.
  input wire [`PLUT_ADDR_W-1:0] reg_addr,   // Offset.
  input wire [7:0]              reg_wdata,  // Write data.
  input wire                    reg_we,     // Write.
  input wire                    reg_re,     // Read.
  input wire [7:0]              reg_rdata,  // Read data.
  input wire                    pix_valid,  // Pixel in.
  input wire [15:0]             pix_data,   // Pixel word.
  input wire                    out_valid,  // Pixel out.
  input wire [OW-1:0]           lcd_red,    // Panel red.
  input wire [OW-1:0]           lcd_green,  // Panel green.
  input wire [OW-1:0]           lcd_blue,   // Panel blue.
  input wire [OW-1:0]           lcd_gray,   // Panel gray.
  input wire [OW-1:0]           crt_red,    // CRT red.
  input wire [OW-1:0]           crt_green,  // CRT green.
  input wire [OW-1:0]           crt_blue,   // CRT blue.
  input wire                    lut_bypass  // Bypass flag.
);
  reg  [5:0]  cf;
  reg  [7:0]  ix;
  reg  [1:0]  bk;
  reg  [15:0] pd;
  reg         pb;
  wire        dat = (reg_we || reg_re) && reg_addr == `PLUT_OFS_DATA;

  // The checker keeps its own copy of config and index, so a stuck
  // register in the design cannot hide behind its own read-back.
  always @(posedge clk) begin
    pd <= pix_data;
    pb <= cf[1];
    if (!rst_n) begin
      cf <= 6'h00;
      ix <= 8'h00;
      bk <= 2'h0;
    end else if (reg_we && reg_addr == `PLUT_OFS_INDEX) begin
      ix <= reg_wdata;
      bk <= 2'h0;
    end else if (dat) begin
      bk <= (bk == 2'h2) ? 2'h0 : bk + 2'h1;
      if (bk == 2'h2)
        ix <= ix + 8'h01;
    end else if (reg_we && reg_addr == `PLUT_OFS_DISP_CFG)
      cf <= reg_wdata[5:0];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_dat_lo;
    reg_re && reg_addr == `PLUT_OFS_DATA |=> reg_rdata[3:0] == 4'h0;
  endproperty
  a_dat_lo: assert property (p_dat_lo) else $error("data low bits set");
  property p_mod_lo;
    reg_re && reg_addr == `PLUT_OFS_MODE |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_mod_lo: assert property (p_mod_lo) else $error("mode high bits set");
  property p_idx;
    reg_re && reg_addr == `PLUT_OFS_INDEX |=> reg_rdata == $past(ix);
  endproperty
  a_idx: assert property (p_idx) else $error("entry index wrong");
  property p_byp;
    pix_valid |=> out_valid && lut_bypass == pb;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass flag wrong");
  property p_px16;
    pix_valid && cf[1:0] == 2'h3 |=> crt_red == {pd[15:11], 1'b0} && crt_green == pd[10:5];
  endproperty
  a_px16: assert property (p_px16) else $error("16 bpp fields wrong");
  property p_px15;
    pix_valid && cf[1:0] == 2'h2 |=> crt_red == {pd[14:10], 1'b0} && crt_blue == {pd[4:0], 1'b0};
  endproperty
  a_px15: assert property (p_px15) else $error("15 bpp fields wrong");
  property p_trim;
    pix_valid && cf[4:1] == 4'hb |=> {lcd_red[1:0], lcd_green[1:0], lcd_blue[1:0]} == 6'h00;
  endproperty
  a_trim: assert property (p_trim) else $error("passive colour not trimmed");
  property p_mono;
    pix_valid && !cf[2] |=> {lcd_red, lcd_green, lcd_blue} == {3*OW{1'b0}};
  endproperty
  a_mono: assert property (p_mono) else $error("mono panel shows colour");

  c_byp: cover property (pix_valid && cf[1]);
  c_mono: cover property (pix_valid && !cf[2] && !cf[1]);
  c_trim: cover property (pix_valid && cf[4:1] == 4'hb);
endmodule // plut_monitor

bind plut_top plut_monitor #(.OW(OW)) plut_monitor_inst (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
  .pix_data(pix_data), .out_valid(out_valid), .lcd_red(lcd_red), .lcd_green(lcd_green),
  .lcd_blue(lcd_blue), .lcd_gray(lcd_gray), .crt_red(crt_red), .crt_green(crt_green),
  .crt_blue(crt_blue), .lut_bypass(lut_bypass)
);

/* File: verif/plut_host_model.sv */
`timescale 1ns/10ps

// ****************************************************************
// Host CPU and display buffer feeding the block.
// ****************************************************************
module plut_host_model (
  input  wire  clk,             // Clock.
  output logic [8:0]  reg_addr,  // Offset.
  output logic [7:0]  reg_wdata, // Write data.
  output logic        reg_we,    // Write.
  output logic        reg_re,    // Read.
  output logic        pix_valid, // Pixel in.
  output logic [15:0] pix_data   // Pixel word.
);
  initial begin
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    pix_valid = 1'b0;
    pix_data = 16'h0000;
  end

  // Released lines show the inverse, so a design that latches late is seen.
  task wr(input [8:0] a, input [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task rd(input [8:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
  endtask

  task px(input [15:0] p);
    @(posedge clk);
    pix_valid <= 1'b1;
    pix_data <= p;
    @(posedge clk);
    pix_valid <= 1'b0;
    pix_data <= ~p;
  endtask
endmodule // plut_host_model

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`include "plut_map.vh"

module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        re_d = 1'b0;
  wire  [8:0]  reg_addr;
  wire  [7:0]  reg_wdata, reg_rdata;
  wire         reg_we, reg_re, pix_valid, out_valid, lut_bypass;
  wire  [15:0] pix_data;
  wire  [5:0]  lcd_red, lcd_green, lcd_blue, lcd_gray, crt_red, crt_green, crt_blue;
  wire  [42:0] ps = {lcd_red, lcd_green, lcd_blue, lcd_gray, crt_red, crt_green, crt_blue,
                     lut_bypass};
  int          error_cnt = 0;
  int          n_compared = 0;
  int          bk = 0;
  logic [7:0]  rq[$];
  logic [42:0] pq[$];
  logic [42:0] pe;
  logic [7:0]  er;
  logic [3:0]  lt[256][3], ct[256][3];
  logic [7:0]  ix = 8'h00;
  logic [1:0]  md = 2'h0;
  logic [5:0]  cf = 6'h00;
  logic [3:0]  v;

  plut_top plut_top_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
    .pix_data(pix_data), .out_valid(out_valid), .lcd_red(lcd_red), .lcd_green(lcd_green),
    .lcd_blue(lcd_blue), .lcd_gray(lcd_gray), .crt_red(crt_red), .crt_green(crt_green),
    .crt_blue(crt_blue), .lut_bypass(lut_bypass));
  plut_host_model plut_host_model_inst (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .pix_valid(pix_valid), .pix_data(pix_data));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task finish_test;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Reference behaviour and register helpers.
  // ****************************************************************
  function logic [42:0] epx(input [15:0] p);
    logic [5:0] r, g, b, y, cr, cg, cb;
    logic [7:0] i;
    i = cf[0] ? p[7:0] : {4'h0, p[3:0]};
    if (cf[1]) begin
      r = cf[0] ? {p[15:11], 1'b0} : {p[14:10], 1'b0};
      g = cf[0] ? p[10:5] : {p[9:5], 1'b0};
      b = {p[4:0], 1'b0};
      {cr, cg, cb} = {r, g, b};
      y = cf[3] ? g : g & 6'h3c;
      if (!cf[3] && cf[4])
        {r, g, b} = {r & 6'h3c, g & 6'h3c, b & 6'h3c};
    end else begin
      {r, g, b} = {lt[i][0], 2'h0, lt[i][1], 2'h0, lt[i][2], 2'h0};
      {cr, cg, cb} = {ct[i][0], 2'h0, ct[i][1], 2'h0, ct[i][2], 2'h0};
      y = g;
    end
    if (cf[2])
      y = 6'h00;
    else
      {r, g, b} = 18'h0;
    return {r, g, b, y, cr, cg, cb, cf[1]};
  endfunction

  task rdr(input [8:0] a, input [7:0] e);
    rq.push_back(e);
    plut_host_model_inst.rd(a);
  endtask
  task adv;
    ix = (bk == 2) ? ix + 8'h01 : ix;
    bk = (bk == 2) ? 0 : bk + 1;
  endtask
  task dwr(input [3:0] d);
    if (md != 2'h2)
      lt[ix][bk] = d;
    if (md != 2'h1)
      ct[ix][bk] = d;
    plut_host_model_inst.wr(`PLUT_OFS_DATA, {d, 4'($urandom)});
    adv();
  endtask
  task drd;
    rdr(`PLUT_OFS_DATA, {md[1] ? ct[ix][bk] : lt[ix][bk], 4'h0});
    adv();
  endtask
  task six(input [7:0] d);
    ix = d;
    bk = 0;
    plut_host_model_inst.wr(`PLUT_OFS_INDEX, d);
  endtask
  task smd(input [1:0] m);
    md = m;
    plut_host_model_inst.wr(`PLUT_OFS_MODE, {6'h3f, m});
  endtask
  task scf(input [5:0] c);
    cf = c;
    plut_host_model_inst.wr(`PLUT_OFS_DISP_CFG, {2'h0, c});
  endtask
  task px(input [15:0] p);
    pq.push_back(epx(p));
    plut_host_model_inst.px(p);
  endtask

  always @(posedge clk) begin
    re_d <= reg_re;
    if (re_d === 1'b1) begin
      er = rq.pop_front();
      chk(reg_rdata, er);
    end
    if (out_valid === 1'b1) begin
      pe = pq.pop_front();
      chk(ps[42:19], pe[42:19]);
      chk(ps[18:0], pe[18:0]);
    end
  end

  initial begin
    #150000;
    error_cnt++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    void'($urandom(32'h31167bfc));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    smd(2'h0);
    rdr(`PLUT_OFS_MODE, 8'h00);
    rdr(`PLUT_OFS_INDEX, 8'h00);
    rdr(9'h1e8, 8'h00);
    six(8'hff);
    repeat (6) dwr(4'($urandom));
    rdr(`PLUT_OFS_INDEX, ix);
    six(8'hff);
    repeat (4) drd();
    dwr(4'h9);
    drd();
    rdr(`PLUT_OFS_INDEX, ix);
    smd(2'h1);
    six(8'h01);
    repeat (3) dwr(4'($urandom));
    smd(2'h2);
    six(8'h01);
    v = 4'($urandom);
    repeat (3) dwr(v);
    smd(2'h3);
    six(8'h01);
    repeat (3) drd();
    smd(2'h0);
    six(8'h01);
    repeat (3) drd();
    rdr(`PLUT_OFS_MODE, 8'h00);
    for (int c = 0; c < 4; c++) begin
      scf({3'h0, c[1], 1'b0, c[0]});
      px(16'hfe01);
      px(16'h3c00);
      px(c[0] ? 16'ha5ff : 16'ha5f0);
    end
    for (int c = 0; c < 16; c++) begin
      scf({1'($urandom), c[3:1], 1'b1, c[0]});
      rdr(`PLUT_OFS_DISP_CFG, {2'h0, cf});
      repeat (3) px(16'($urandom));
    end
    // Rewriting the index with the bank on green must start again at red.
    six(8'h00);
    drd();
    six(8'h00);
    drd();
    // A second reset in mid-run must bring the registers back to zero and
    // the bank pointer, left on green here, back to red.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bk = 0;
    cf = 6'h00;
    rdr(`PLUT_OFS_INDEX, 8'h00);
    rdr(`PLUT_OFS_DISP_CFG, 8'h00);
    rdr(`PLUT_OFS_MODE, 8'h00);
    drd();
    repeat (3) @(posedge clk);
    chk(pq.size() + rq.size(), 0);
    finish_test();
  end
endmodule // testbench
